// ==== spi_port_map.svh ====
`ifndef SPI_PORT_MAP_SVH
`define SPI_PORT_MAP_SVH

// ==========================================
// Register byte offsets on the APB bus
`define OFS_CONTROL 12'h000
`define OFS_STATUS 12'h004
`define OFS_DATA 12'h008

// ==========================================
// Control register fields
`define CTL_IRQ_EN 7
`define CTL_ON 6
`define CTL_LSB_FIRST 5
`define CTL_HOST 4
`define CTL_IDLE_LVL 3
`define CTL_PHASE 2
`define CTL_RATE_HI 1
`define CTL_RATE_LO 0
`define CTL_RESET 8'h00

// ==========================================
// Status register fields
`define STS_DONE 7
`define STS_WRITE_COLLISION_FLAG 6
`define STS_DBL 0

// ==========================================
// Pin vector positions inside the synchroniser
`define PIN_SCK 0
`define PIN_MOSI 1
`define PIN_MISO 2
`define PIN_SS 3

// ==========================================
// Half SCK periods in system clocks, per rate code; last host edge and last slave sample counts
`define HALF_DIV4 7'h02
`define HALF_DIV16 7'h08
`define HALF_DIV64 7'h20
`define HALF_DIV128 7'h40
`define HALF_DIV2 7'h01
`define HALF_DIV8 7'h04
`define HALF_DIV32 7'h10
`define LAST_EDGE 4'hF
`define LAST_SAMPLE 4'h7

`endif

// ==== spi_port_pkg.sv ====
package spi_port_pkg;

    // ==========================================
    // APB request and answer
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    // ==========================================
    // Serial pins, inputs and driven side
    typedef struct packed {
        logic ss_n;
        logic miso;
        logic mosi;
        logic sck;
    } spi_pins_in_t;

    typedef struct packed {
        logic sck;
        logic sck_oe_n;
        logic mosi;
        logic mosi_oe_n;
        logic miso;
        logic miso_oe_n;
    } spi_pins_out_t;

    // ==========================================
    // Transfer engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HOST = 3'b010,
        ST_SLAVE = 3'b100
    } xfer_state_t;

    // ==========================================
    // Whole state of the port
    typedef struct packed {
        logic [7:0] ctrl;
        logic dbl;
        logic done;
        logic write_collision_flag;
        logic seen_done;
        logic seen_write_collision_flag;
        xfer_state_t st;
        logic [7:0] shreg;
        logic [7:0] txb;
        logic [7:0] rxbuf;
        logic [3:0] edges;
        logic [6:0] divc;
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] pf;
        apb_rsp_t rsp;
        spi_pins_out_t pins;
        logic irq;
    } port_state_t;

endpackage

// ==== spi_master_slave_port.sv ====
// Function
// [RULE_01] Slave: select low activates, MISO optional
// [RULE_02] Select rising resets slave logic and count
// [RULE_03] Output select pin ignored by port
// [RULE_04] Input select low demotes host to slave
// [RULE_05] Demotion also sets transfer done flag
// [RULE_06] Interrupt when done, enable, global enable
// [RULE_07] No serial activity unless port on
// [RULE_08] Order bit one sends LSB first
// [RULE_09] Idle level bit sets SCK idle level
// [RULE_10] Phase picks sample and setup edges
// [RULE_11] Mode number is polarity then phase
// [RULE_12] Host SCK divides system clock by code
// [RULE_13] Rate bits ignored in slave role
// [RULE_14] Double rate halves host SCK period
// [RULE_15] External SCK at most quarter clock
// [RULE_16] Done flag set per completed byte
// [RULE_17] Done clears on vector or status-data
// [RULE_18] Data write mid-transfer sets collision
// [RULE_19] Status-data sequence clears both flags
// [RULE_20] Status bits five to one read zero
// [RULE_21] Data write starts, read gives buffer
// [RULE_22] Handler rechecks and restores host role
// [RULE_23] Eight bits per byte, clock then stops
// [RULE_24] Received byte buffered until next completes
// [RULE_25] External SCK phases over two clocks
// [RULE_26] Colliding data write is dropped
// [RULE_27] Slave pins synchronised, edges found locally
`timescale 1ns/1ps
`include "spi_port_map.svh"

module spi_master_slave_port
    import spi_port_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire apb_req_t apb_in,
    output apb_rsp_t apb_out,
    input wire spi_pins_in_t pins_in,
    input wire logic ss_dir_output_in,
    input wire logic miso_dir_output_in,
    input wire logic global_irq_en_in,
    input wire logic irq_ack_in,
    output spi_pins_out_t pins_out,
    output logic irq_out
);

    port_state_t r_reg;
    port_state_t r_next;

    // ==========================================
    // Half period of the host clock
    // Slave timing follows the external SCK, so this is
    // only consulted by the host engine
    function automatic logic [6:0] half_period(
        input logic dbl,
        input logic [1:0] code
    );
        logic [6:0] h;
        h = `HALF_DIV4;
        case ({dbl, code})
            3'b000: h = `HALF_DIV4;
            3'b001: h = `HALF_DIV16;
            3'b010: h = `HALF_DIV64;
            3'b011: h = `HALF_DIV128;
            3'b100: h = `HALF_DIV2;
            3'b101: h = `HALF_DIV8;
            3'b110: h = `HALF_DIV32;
            default: h = `HALF_DIV64;
        endcase
        return h;
    endfunction

    // ==========================================
    // Next-state logic
    always_comb begin
        logic on;
        logic host;
        logic clock_idle_level;
        logic clock_sample_phase;
        logic lsb;
        logic in_bit;
        logic [7:0] shifted;
        logic take;
        logic setup;
        logic is_ctl;
        logic is_sts;
        logic is_dat;
        logic busy;
        logic tick;
        logic lead;
        logic sck_edge;
        logic ss_rise;
        logic demote;
        logic [7:0] rd;

        n_init: begin
        end
        r_next = r_reg;
        on = r_reg.ctrl[`CTL_ON];
        host = r_reg.ctrl[`CTL_HOST];
        clock_idle_level = r_reg.ctrl[`CTL_IDLE_LVL];
        clock_sample_phase = r_reg.ctrl[`CTL_PHASE];
        lsb = r_reg.ctrl[`CTL_LSB_FIRST];

        // Three-stage pin filter; a level counts once stages
        // two and three agree, so a single glitch is dropped
        r_next.s1 = pins_in;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        for (int i = 0; i < 4; i++) begin
            if (r_reg.s2[i] == r_reg.s3[i]) begin
                r_next.pf[i] = r_reg.s3[i]; // [RULE_27]
            end
        end
        sck_edge = (r_next.pf[`PIN_SCK] != r_reg.pf[`PIN_SCK]); // [RULE_27]
        ss_rise = r_next.pf[`PIN_SS] && !r_reg.pf[`PIN_SS]; // [RULE_02]

        // Host samples MISO, slave samples MOSI
        in_bit = host ? r_reg.pf[`PIN_MISO] : r_reg.pf[`PIN_MOSI];
        shifted = lsb ? {in_bit, r_reg.shreg[7:1]}
                      : {r_reg.shreg[6:0], in_bit}; // [RULE_08]

        // Slave is busy only once a bit has been sampled
        busy = (r_reg.st == ST_HOST) ||
               ((r_reg.st == ST_SLAVE) && (r_reg.edges != 4'h0));

        // ==========================================
        // APB decode: answer one cycle after setup
        setup = apb_in.psel && !apb_in.penable;
        take = apb_in.psel && apb_in.penable && r_reg.rsp.pready;
        is_ctl = (apb_in.paddr == `OFS_CONTROL);
        is_sts = (apb_in.paddr == `OFS_STATUS);
        is_dat = (apb_in.paddr == `OFS_DATA);
        r_next.rsp.pready = setup;
        r_next.rsp.pslverr = setup && !(is_ctl || is_sts || is_dat);
        rd = 8'h00;
        if (is_ctl) begin
            rd = r_reg.ctrl;
        end else if (is_sts) begin
            rd = {r_reg.done, r_reg.write_collision_flag, 5'h00, r_reg.dbl}; // [RULE_20]
        end else if (is_dat) begin
            rd = r_reg.rxbuf; // [RULE_21]
        end
        r_next.rsp.prdata = setup ? {24'h000000, rd} : 32'h00000000;

        // ==========================================
        // Flag clears come first so a same-cycle set wins
        if (irq_ack_in) begin
            r_next.done = 1'b0; // [RULE_17]
        end
        if (take && is_dat) begin
            if (r_reg.seen_done || r_reg.seen_write_collision_flag) begin
                r_next.done = 1'b0; // [RULE_17] [RULE_19]
            end
            if (r_reg.seen_write_collision_flag) begin
                r_next.write_collision_flag = 1'b0; // [RULE_19]
            end
            r_next.seen_done = 1'b0;
            r_next.seen_write_collision_flag = 1'b0;
        end
        if (take && !apb_in.pwrite && is_sts) begin
            r_next.seen_done = r_reg.done;
            r_next.seen_write_collision_flag = r_reg.write_collision_flag;
        end

        // ==========================================
        // Register writes
        if (take && apb_in.pwrite && is_ctl) begin
            r_next.ctrl = apb_in.pwdata[7:0];
        end
        if (take && apb_in.pwrite && is_sts) begin
            r_next.dbl = apb_in.pwdata[`STS_DBL];
        end
        if (take && apb_in.pwrite && is_dat) begin
            if (busy) begin
                r_next.write_collision_flag = 1'b1; // [RULE_18] [RULE_26]
            end else begin
                r_next.shreg = apb_in.pwdata[7:0];
                r_next.txb = apb_in.pwdata[7:0];
                if (on && host) begin
                    // Start the host clock generator
                    r_next.st = ST_HOST; // [RULE_21] [RULE_23]
                    r_next.edges = 4'h0;
                    r_next.divc = 7'h00;
                    r_next.pins.mosi = lsb ? apb_in.pwdata[0]
                                           : apb_in.pwdata[7];
                end
            end
        end

        // ==========================================
        // Host engine: one tick per half SCK period
        tick = (r_reg.divc == half_period(r_reg.dbl,
                 r_reg.ctrl[`CTL_RATE_HI:`CTL_RATE_LO]) - 7'h01); // [RULE_12] [RULE_14]
        lead = !r_reg.edges[0];
        if (r_reg.st == ST_HOST) begin
            r_next.divc = tick ? 7'h00 : r_reg.divc + 7'h01;
            if (tick) begin
                // Leading edge leaves the idle level
                r_next.pins.sck = lead ? !clock_idle_level : clock_idle_level; // [RULE_09]
                if (lead ^ clock_sample_phase) begin
                    r_next.shreg = shifted; // [RULE_10] [RULE_11]
                end else begin
                    r_next.pins.mosi = lsb ? r_reg.shreg[0]
                                           : r_reg.shreg[7]; // [RULE_10]
                end
                r_next.edges = r_reg.edges + 4'h1;
                if (r_reg.edges == `LAST_EDGE) begin
                    // Clock stops after the eighth bit
                    r_next.st = ST_IDLE; // [RULE_23]
                    r_next.done = 1'b1; // [RULE_16]
                    r_next.rxbuf = r_next.shreg; // [RULE_24]
                end
            end
        end

        // ==========================================
        // Slave engine driven by filtered external SCK
        if (r_reg.st == ST_SLAVE) begin
            if (sck_edge) begin
                lead = (r_next.pf[`PIN_SCK] != clock_idle_level); // [RULE_09]
                if (lead ^ clock_sample_phase) begin
                    r_next.shreg = shifted; // [RULE_10]
                    r_next.edges = r_reg.edges + 4'h1;
                    if (r_reg.edges == `LAST_SAMPLE) begin
                        r_next.edges = 4'h0;
                        r_next.done = 1'b1; // [RULE_16]
                        r_next.rxbuf = shifted; // [RULE_24]
                    end
                end else begin
                    r_next.pins.miso = lsb ? r_reg.shreg[0]
                                           : r_reg.shreg[7]; // [RULE_10]
                end
            end else if (r_reg.edges == 4'h0) begin
                // First bit must stand before the first edge
                r_next.pins.miso = lsb ? r_next.shreg[0] : r_next.shreg[7];
            end
            if (ss_rise || host || !on) begin
                // Partial byte is dropped, data reloaded
                r_next.st = ST_IDLE; // [RULE_02]
                r_next.edges = 4'h0;
                r_next.shreg = r_reg.txb; // [RULE_02]
            end
        end else if (r_reg.st == ST_IDLE) begin
            r_next.pins.sck = clock_idle_level; // [RULE_09]
            if (on && !host && !r_reg.pf[`PIN_SS]) begin
                r_next.st = ST_SLAVE; // [RULE_01] [RULE_13]
                r_next.edges = 4'h0;
            end
        end

        // ==========================================
        // Another master pulled select low: fall back
        // An output select is a plain GPIO and never looked at
        demote = on && host && !ss_dir_output_in
                 && !r_reg.pf[`PIN_SS]; // [RULE_03] [RULE_04]
        if (demote) begin
            r_next.ctrl[`CTL_HOST] = 1'b0; // [RULE_04]
            r_next.done = 1'b1; // [RULE_05]
            r_next.st = ST_IDLE;
            r_next.edges = 4'h0;
        end
        if (!on) begin
            r_next.st = ST_IDLE; // [RULE_07]
            r_next.edges = 4'h0;
        end

        // ==========================================
        // Pin drive; low enable means driving
        r_next.pins.sck_oe_n = !(on && host && !demote); // [RULE_04] [RULE_07]
        r_next.pins.mosi_oe_n = !(on && host && !demote);
        r_next.pins.miso_oe_n = !(on && !host && !r_reg.pf[`PIN_SS]
                                  && miso_dir_output_in); // [RULE_01]

        // Interrupt request level
        r_next.irq = r_next.done && r_next.ctrl[`CTL_IRQ_EN]
                     && global_irq_en_in; // [RULE_06]
    end

    // ==========================================
    // State register
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            r_reg <= '0;
            r_reg.ctrl <= `CTL_RESET;
            r_reg.st <= ST_IDLE;
            r_reg.s1 <= 4'hF;
            r_reg.s2 <= 4'hF;
            r_reg.s3 <= 4'hF;
            r_reg.pf <= 4'hF;
            r_reg.pins.sck_oe_n <= 1'b1;
            r_reg.pins.mosi_oe_n <= 1'b1;
            r_reg.pins.miso_oe_n <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs come straight from the state register
    assign apb_out = r_reg.rsp;
    assign pins_out = r_reg.pins;
    assign irq_out = r_reg.irq;

endmodule

// ==== spi_port_monitor.sv ====
`timescale 1ns/1ps
`include "spi_port_map.svh"
// ==========================================
// Port checks on bus answers, serial pins and interrupt
module spi_port_monitor
    import spi_port_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire apb_req_t apb_in,
    input wire apb_rsp_t apb_out,
    input wire spi_pins_in_t pins_in,
    input wire logic ss_dir_output_in,
    input wire logic miso_dir_output_in,
    input wire logic global_irq_en_in,
    input wire logic irq_ack_in,
    input wire spi_pins_out_t pins_out,
    input wire logic irq_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    logic [5:0] edge_n;
    logic sck_q;
    // Driven SCK edges since the last data or control write; a clock that fails to stop runs past 16
    always_ff @(posedge sys_clk_in) begin
        sck_q <= pins_out.sck;
        if (!resetn_in || (apb_in.psel && apb_in.penable && apb_out.pready && apb_in.pwrite
            && (apb_in.paddr == `OFS_DATA || apb_in.paddr == `OFS_CONTROL))) begin
            edge_n <= 6'h00;
        end else if (!pins_out.sck_oe_n && pins_out.sck != sck_q && edge_n != 6'h3F) begin
            edge_n <= edge_n + 6'h01;
        end
    end
    sequence setup_phase;
        apb_in.psel && !apb_in.penable;
    endsequence
    sequence bus_take;
        apb_in.psel && apb_in.penable && apb_out.pready;
    endsequence
    a_status_rsv_zero:
        assert property (bus_take ##0 (!apb_in.pwrite && apb_in.paddr == `OFS_STATUS)
            |-> apb_out.prdata[5:1] == 5'h00 && apb_out.prdata[31:8] == 24'h000000)
        else $error("status reserved bits not zero");
    a_ready_zero_wait:
        assert property (setup_phase |=> apb_out.pready)
        else $error("register access not answered at once");
    a_err_unmapped:
        assert property (bus_take ##0 (apb_in.paddr > `OFS_DATA)
            |-> apb_out.pslverr && apb_out.prdata == 32'h00000000)
        else $error("unmapped access not refused");
    a_irq_needs_gie:
        assert property (!global_irq_en_in |=> !irq_out)
        else $error("interrupt without global enable");
    a_irq_ack_clears:
        assert property (irq_ack_in |-> ##2 !irq_out)
        else $error("interrupt stays after vector taken");
    a_miso_quiet:
        assert property (pins_in.ss_n [*8] |=> pins_out.miso_oe_n)
        else $error("MISO driven while deselected");
    a_demote_release:
        assert property ((!ss_dir_output_in && !pins_in.ss_n) [*8]
            |=> pins_out.sck_oe_n && pins_out.mosi_oe_n)
        else $error("SCK or MOSI driven after demotion");
    a_eight_bits:
        assert property (edge_n <= 6'h10)
        else $error("more than sixteen SCK edges per byte");
endmodule

bind spi_master_slave_port spi_port_monitor spi_port_monitor_i (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .apb_in(apb_in), .apb_out(apb_out),
    .pins_in(pins_in), .ss_dir_output_in(ss_dir_output_in),
    .miso_dir_output_in(miso_dir_output_in), .global_irq_en_in(global_irq_en_in),
    .irq_ack_in(irq_ack_in), .pins_out(pins_out), .irq_out(irq_out));

// ==== spi_peer_model.sv ====
`timescale 1ns/1ps
// ==========================================
// Far-side peripheral: one byte per select, MSB first
module spi_peer_model (
    input wire logic sck_in,
    input wire logic mosi_in,
    input wire logic sel_n_in,
    input wire logic [1:0] mode_in,
    input wire logic [7:0] tx_in,
    output logic miso_out,
    output logic [7:0] rx_out
);
    int k;
    initial begin
        miso_out = 1'b0;
        rx_out = 8'h00;
    end
    task automatic put_bit();
        miso_out = tx_in[7 - k];
        k = k + 1;
    endtask
    // Phase zero needs its first bit before the first edge
    always @(negedge sel_n_in) begin
        k = 0;
        rx_out = 8'h00;
        if (!mode_in[0]) put_bit();
    end
    // Released line has no pull, so it must not hold the last bit
    always @(posedge sel_n_in) miso_out = ~miso_out;
    // Leading edge leaves the idle level; phase picks sample or setup on it
    always @(sck_in) begin
        if (!sel_n_in) begin
            if ((sck_in != mode_in[1]) != mode_in[0]) begin
                rx_out = {rx_out[6:0], mosi_in};
            end else if (k < 8) begin
                put_bit();
            end
        end
    end
endmodule

// ==== spi_master_slave_port_tb.sv ====
`timescale 1ns/1ps
`include "spi_port_map.svh"
module spi_master_slave_port_tb;
    import spi_port_pkg::*;
    logic sys_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    spi_pins_out_t pins_o;
    logic ss_n = 1'b1, mosi = 1'b0, sck = 1'b0, ss_dir = 1'b0, gie = 1'b0, ack = 1'b0;
    logic irq, peer_miso, last_err, sck_q = 1'b0, peer_sel_n = 1'b1;
    logic [1:0] peer_mode = 2'h0;
    logic [7:0] peer_tx = 8'h00, peer_rx;
    int bad_count = 0, n_checks = 0, cyc = 0, last_tog = 0, gap = 0, tog_n = 0;
    // ==========================================
    // Clock, design and far side
    always #50 sys_clk_in = ~sys_clk_in;
    spi_master_slave_port spi_master_slave_port_i (.sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in), .apb_in(req), .apb_out(rsp), .pins_in({ss_n, peer_miso, mosi, sck}),
        .ss_dir_output_in(ss_dir), .miso_dir_output_in(1'b1), .global_irq_en_in(gie),
        .irq_ack_in(ack), .pins_out(pins_o), .irq_out(irq));
    spi_peer_model spi_peer_model_i (.sck_in(pins_o.sck), .mosi_in(pins_o.mosi),
        .sel_n_in(peer_sel_n), .mode_in(peer_mode), .tx_in(peer_tx), .miso_out(peer_miso),
        .rx_out(peer_rx));
    // Spacing and count of SCK changes, in system clocks
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        sck_q <= pins_o.sck;
        if (pins_o.sck !== sck_q) begin
            gap <= cyc - last_tog;
            last_tog <= cyc;
            tog_n <= tog_n + 1;
        end
    end
    // ==========================================
    // Shared helpers
    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask
    // Request held until pready; one idle cycle after, so req is never set twice at one edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] v,
        output logic [31:0] d);
        int n;
        n = 0;
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: {24'h000000, v}};
        @(posedge sys_clk_in);
        req.penable <= 1'b1;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        d = rsp.prdata;
        last_err = rsp.pslverr;
        req <= '0;
        @(posedge sys_clk_in);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_regs();
        logic [31:0] d;
        apb(1'b0, `OFS_CONTROL, 8'h00, d);
        chk("control reset", 32'h00, d);
        apb(1'b1, `OFS_CONTROL, 8'hA5, d);
        apb(1'b0, `OFS_CONTROL, 8'h00, d);
        chk("control readback", 32'hA5, d);
        apb(1'b1, `OFS_STATUS, 8'hFF, d);
        apb(1'b0, `OFS_STATUS, 8'h00, d);
        chk("status read", 32'h01, d);
        apb(1'b0, 12'h00C, 8'h00, d);
        chk("unmapped error", 1'b1, last_err);
        $display("test regs done");
    endtask
    // Select pin held low as a plain output must not disturb the host
    task automatic t_host(input logic [2:0] code, input logic collide);
        logic [31:0] d;
        logic [7:0] tx;
        logic [1:0] md;
        logic lsb;
        int half, t0, i;
        lsb = code[2] ^ code[0];
        md = code[1:0] ^ {2{code[2]}};
        half = ((code[1:0] == 2'h3) ? 64 : (2 << (2 * code[1:0]))) >> code[2];
        tx = 8'h5A + {5'h00, code};
        ss_dir <= 1'b1;
        ss_n <= 1'b0;
        peer_mode <= md;
        peer_tx <= 8'hC3 ^ {5'h00, code};
        apb(1'b1, `OFS_STATUS, {7'h00, code[2]}, d);
        apb(1'b1, `OFS_CONTROL, {2'h1, lsb, 1'b1, md, code[1:0]}, d);
        // An idle level change is not a data edge, so let it settle first
        repeat (2) @(posedge sys_clk_in);
        peer_sel_n <= 1'b0;
        @(posedge sys_clk_in);
        t0 = tog_n;
        apb(1'b1, `OFS_DATA, tx, d);
        if (collide) apb(1'b1, `OFS_DATA, 8'hFF, d);
        i = 0;
        do begin
            apb(1'b0, `OFS_STATUS, 8'h00, d);
            i++;
        end while (d[7] !== 1'b1 && i < 400);
        chk("collision flag", collide, d[6]);
        chk("edge count", 16, tog_n - t0);
        chk("half period", half, gap);
        chk("idle level", md[1], pins_o.sck);
        chk("bits sent", lsb ? rev8(tx) : tx, peer_rx);
        apb(1'b0, `OFS_DATA, 8'h00, d);
        if (half > 4) chk("bits taken", lsb ? rev8(peer_tx) : peer_tx, d);
        apb(1'b0, `OFS_STATUS, 8'h00, d);
        chk("flags cleared", 2'h0, d[7:6]);
        peer_sel_n <= 1'b1;
        ss_n <= 1'b1;
        $display("test host code %0d done", code);
    endtask
    // Bench as far master, mode 0, half period of 8 clocks
    task automatic send(input int n, input logic [7:0] v, output logic [7:0] got);
        ss_n <= 1'b0;
        repeat (8) @(posedge sys_clk_in);
        for (int i = 0; i < n; i++) begin
            mosi <= v[7 - i];
            repeat (8) @(posedge sys_clk_in);
            sck <= 1'b1;
            got = {got[6:0], pins_o.miso};
            repeat (8) @(posedge sys_clk_in);
            sck <= 1'b0;
        end
        repeat (8) @(posedge sys_clk_in);
        ss_n <= 1'b1;
        mosi <= ~mosi;
        repeat (8) @(posedge sys_clk_in);
    endtask
    task automatic t_slave(input logic on);
        logic [31:0] d;
        logic [7:0] got;
        ss_dir <= 1'b0;
        apb(1'b1, `OFS_CONTROL, {1'b0, on, 6'h03}, d);
        apb(1'b1, `OFS_DATA, 8'h96, d);
        send(3, 8'h00, got);
        send(8, 8'h3B, got);
        apb(1'b0, `OFS_STATUS, 8'h00, d);
        chk("slave done", on, d[7]);
        apb(1'b0, `OFS_DATA, 8'h00, d);
        if (on) chk("slave byte", 8'h3B, d);
        if (on) chk("slave reply", 8'h96, got);
        $display("test slave on %0b done", on);
    endtask
    task automatic t_demote();
        logic [31:0] d;
        gie <= 1'b1;
        apb(1'b1, `OFS_CONTROL, 8'hD0, d);
        ss_n <= 1'b0;
        repeat (10) @(posedge sys_clk_in);
        ss_n <= 1'b1;
        chk("irq raised", 1'b1, irq);
        apb(1'b0, `OFS_CONTROL, 8'h00, d);
        chk("host dropped", 8'hC0, d);
        apb(1'b0, `OFS_STATUS, 8'h00, d);
        chk("demote done", 1'b1, d[7]);
        ack <= 1'b1;
        @(posedge sys_clk_in);
        ack <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        chk("irq cleared", 1'b0, irq);
        $display("test demote done");
    endtask
    // ==========================================
    // Main sequence and watchdog
    initial begin
        repeat (2) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        @(posedge sys_clk_in);
        t_regs();
        for (int c = 0; c < 8; c++) t_host(c[2:0], c == 1);
        t_slave(1'b1);
        t_slave(1'b0);
        t_demote();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        bad_count++;
        $display("[FAIL] watchdog expected finish seen timeout");
        complete_run();
    end
endmodule
